// >>> verilog/memctl_config_tables.sv
// Indexed configuration bank, table RAMs and address attribute decode
`timescale 1ns/10ps
`default_nettype none
module memctl_config_tables
    import memctl_cfg_pkg::*;
#(
    parameter int RAM_DEPTH   = 32,
    parameter int TIMEOUT_CYC = RAS_TIMEOUT_CYC
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire io_req_t      host_req_in,
    input  wire logic [13:0]  host_address_bus_in,
    input  wire logic         cycle_valid_in,
    input  wire logic         cycle_write_in,
    input  wire logic         dma_grant_in,
    input  wire logic         write_buffer_empty_in,
    input  wire logic         ras_active_in,
    output logic [7:0]        host_data_bus_out,
    output dram_timing_t      timing_out,
    output logic [1:0]        bus_recovery_out,
    output logic [1:0]        bus_speed_out,
    output logic              early_write_end_out,
    output logic              dma_bridge_en_out,
    output logic              io_decode_16_out,
    output logic              data_pipeline_en_out,
    output logic              middle_bios_en_out,
    output logic              write_pipe_off_out,
    output logic              memctl_ready_n_out,
    output logic              ras_timeout_out,
    output logic              dram_select_out,
    output logic              non_cacheable_out,
    output logic              translate_hit_out,
    output logic [13:0]       translated_page_out,
    output logic [4:0]        remap_phys_page_out
);

    logic [7:0]  index_reg;
    logic [7:0]  cas_timing;
    logic [7:0]  ras_timing_options;
    logic [7:0]  transfer_control_port;
    logic [7:0]  table_ram_address;
    logic [7:0]  transfer_data_port;
    logic [7:0]  misc_options;
    logic [7:0]  bus_speed_options;
    logic [13:0] upper_cache_limit;
    logic [5:0]  low_noncache_window_start;
    logic [5:0]  low_noncache_window_end;
    logic [13:0] remap_ceiling_value;
    logic [13:0] installed_ceiling_value;
    logic [13:0] page_translation_entry [RAM_DEPTH];
    logic [4:0]  remap_table_entry      [RAM_DEPTH];
    logic [5:0]  page_descriptor        [RAM_DEPTH];
    flow_state_t flow_state;
    logic [15:0] ras_count;

    logic        data_wr;
    logic        ctrl_wr;
    logic        xfer_go;
    logic        xfer_dir_wr;
    logic [3:0]  xfer_tgt;
    logic [4:0]  ram_idx;
    logic [7:0]  next_read_data;
    logic [7:0]  xfer_read_data;

    // Data port writes land in the indexed register
    assign data_wr     = host_req_in.wr && host_req_in.addr == IO_DATA_PORT;
    assign ctrl_wr     = data_wr && index_reg == IDX_XFER_CTRL;
    assign xfer_go     = ctrl_wr && host_req_in.data[XFER_GO_BIT];
    assign xfer_dir_wr = host_req_in.data[XFER_DIR_BIT];
    assign xfer_tgt    = host_req_in.data[3:0];
    assign ram_idx     = table_ram_address[4:0];

    // Index port
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            index_reg <= RST_BYTE_ZERO;
        end else if (host_req_in.wr && host_req_in.addr == IO_INDEX_PORT) begin
            index_reg <= host_req_in.data;
        end
    end

    // Static option registers; reserved bits kept as written
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cas_timing            <= RST_CAS_TIMING;
            ras_timing_options    <= RST_RAS_TIMING;
            table_ram_address     <= RST_BYTE_ZERO;
            misc_options          <= RST_BYTE_ZERO;
            bus_speed_options     <= RST_BUS_SPEED;
            transfer_control_port <= RST_BYTE_ZERO;
        end else if (data_wr) begin
            if (index_reg == IDX_CAS_TIMING) begin
                cas_timing <= host_req_in.data;
            end else if (index_reg == IDX_RAS_TIMING) begin
                ras_timing_options <= host_req_in.data;
            end else if (index_reg == IDX_RAM_ADDR) begin
                table_ram_address <= host_req_in.data;
            end else if (index_reg == IDX_MISC_OPT) begin
                misc_options <= host_req_in.data;
            end else if (index_reg == IDX_BUS_SPEED) begin
                bus_speed_options <= host_req_in.data;
            end else if (index_reg == IDX_XFER_CTRL) begin
                // Start bit is not kept
                transfer_control_port <= {1'b0, host_req_in.data[6:0]};
            end
        end
    end

    // Data register: host writes, or read transfers refill it in the same
    // edge as the control write, so the very next access sees it.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            transfer_data_port <= RST_BYTE_ZERO;
        end else if (xfer_go && !xfer_dir_wr) begin
            transfer_data_port <= xfer_read_data;
        end else if (data_wr && index_reg == IDX_XFER_DATA) begin
            transfer_data_port <= host_req_in.data;
        end
    end

    // Source value for a read transfer
    always_comb begin
        xfer_read_data = 8'h00;
        case (xfer_tgt)
            TGT_TRANS_MSB:
                xfer_read_data = {2'b00, page_translation_entry[ram_idx][13:8]};
            TGT_TRANS_LSB:
                xfer_read_data = page_translation_entry[ram_idx][7:0];
            TGT_REMAP_RAM:
                xfer_read_data = {3'b000, remap_table_entry[ram_idx]};
            TGT_DESC_RAM:
                xfer_read_data = {2'b00, page_descriptor[ram_idx]};
            TGT_CACHE_MSB:
                xfer_read_data = {2'b00, upper_cache_limit[13:8]};
            TGT_CACHE_LSB:
                xfer_read_data = upper_cache_limit[7:0];
            TGT_WIN_START:
                xfer_read_data = {2'b00, low_noncache_window_start};
            TGT_WIN_END:
                xfer_read_data = {2'b00, low_noncache_window_end};
            TGT_REMAP_MSB:
                xfer_read_data = {2'b00, remap_ceiling_value[13:8]};
            TGT_REMAP_LSB:
                xfer_read_data = remap_ceiling_value[7:0];
            TGT_INST_MSB:
                xfer_read_data = {2'b00, installed_ceiling_value[13:8]};
            TGT_INST_LSB:
                xfer_read_data = installed_ceiling_value[7:0];
            default:
                xfer_read_data = 8'h00;
        endcase
    end

    // Register-like targets of write transfers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            upper_cache_limit         <= RST_CEILING;
            low_noncache_window_start <= RST_WINDOW_START;
            low_noncache_window_end   <= RST_WINDOW_END;
            remap_ceiling_value       <= RST_CEILING;
            installed_ceiling_value   <= RST_CEILING;
        end else if (xfer_go && xfer_dir_wr) begin
            case (xfer_tgt)
                TGT_CACHE_MSB:
                    upper_cache_limit[13:8] <= transfer_data_port[5:0];
                TGT_CACHE_LSB:
                    upper_cache_limit[7:0] <= transfer_data_port;
                TGT_WIN_START:
                    low_noncache_window_start <= transfer_data_port[5:0];
                TGT_WIN_END:
                    low_noncache_window_end <= transfer_data_port[5:0];
                TGT_REMAP_MSB:
                    remap_ceiling_value[13:8] <= transfer_data_port[5:0];
                TGT_REMAP_LSB:
                    remap_ceiling_value[7:0] <= transfer_data_port;
                TGT_INST_MSB:
                    installed_ceiling_value[13:8] <= transfer_data_port[5:0];
                TGT_INST_LSB:
                    installed_ceiling_value[7:0] <= transfer_data_port;
                default: ;
            endcase
        end
    end

    // Table RAM entries, one write port each
    generate
        for (genvar i = 0; i < RAM_DEPTH; i++) begin : g_ram
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    page_translation_entry[i] <= RST_TRANSLATION;
                    remap_table_entry[i]      <= RST_REMAP_ENTRY;
                    page_descriptor[i]        <= RST_DESCRIPTOR;
                end else if (xfer_go && xfer_dir_wr && ram_idx == i) begin
                    if (xfer_tgt == TGT_TRANS_MSB) begin
                        page_translation_entry[i][13:8] <=
                            transfer_data_port[5:0];
                    end else if (xfer_tgt == TGT_TRANS_LSB) begin
                        page_translation_entry[i][7:0] <= transfer_data_port;
                    end else if (xfer_tgt == TGT_REMAP_RAM) begin
                        remap_table_entry[i] <= transfer_data_port[4:0];
                    end else if (xfer_tgt == TGT_DESC_RAM) begin
                        page_descriptor[i] <= transfer_data_port[5:0];
                    end
                end
            end
        end
    endgenerate

    // Read-back of the indexed register
    always_comb begin
        next_read_data = 8'h00;
        if (index_reg == IDX_CAS_TIMING) begin
            next_read_data = cas_timing;
        end else if (index_reg == IDX_RAS_TIMING) begin
            next_read_data = ras_timing_options;
        end else if (index_reg == IDX_XFER_CTRL) begin
            next_read_data = transfer_control_port;
        end else if (index_reg == IDX_RAM_ADDR) begin
            next_read_data = table_ram_address;
        end else if (index_reg == IDX_XFER_DATA) begin
            next_read_data = transfer_data_port;
        end else if (index_reg == IDX_MISC_OPT) begin
            next_read_data = misc_options;
        end else if (index_reg == IDX_BUS_SPEED) begin
            next_read_data = bus_speed_options;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            host_data_bus_out <= 8'h00;
        end else if (host_req_in.rd && host_req_in.addr == IO_DATA_PORT) begin
            host_data_bus_out <= next_read_data;
        end else if (host_req_in.rd && host_req_in.addr == IO_INDEX_PORT) begin
            host_data_bus_out <= index_reg;
        end
    end

    // Timing fields as counts of clocks; option bits registered, bridge bit inverted
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            timing_out           <= '0;
            bus_recovery_out     <= 2'h0;
            bus_speed_out        <= 2'h0;
            early_write_end_out  <= 1'b0;
            dma_bridge_en_out    <= 1'b0;
            io_decode_16_out     <= 1'b0;
            data_pipeline_en_out <= 1'b0;
            middle_bios_en_out   <= 1'b0;
        end else begin
            timing_out.row_strobe_precharge <=
                {1'b0, ras_timing_options[1:0]} + 3'h1;
            timing_out.ras_active_read <=
                {1'b0, ras_timing_options[4:2]} + 4'h2;
            timing_out.ras_active_write <=
                {1'b0, ras_timing_options[6:5]} + 3'h2;
            timing_out.ras_delay <= ras_timing_options[7];
            timing_out.cas_active_read <= {1'b0, cas_timing[0]} + 2'h1;
            timing_out.cas_active_write <= {1'b0, cas_timing[1]} + 2'h1;
            timing_out.col_strobe_read_delay <= {1'b0, cas_timing[2]} + 2'h1;
            timing_out.col_strobe_write_delay <= {1'b0, cas_timing[3]} + 2'h1;
            timing_out.cas_burst_delay <= {1'b0, cas_timing[4]} + 2'h1;
            timing_out.col_strobe_precharge <= {1'b0, cas_timing[5]} + 2'h1;
            timing_out.cas_hold <= {1'b0, cas_timing[7]} + 2'h1;
            bus_recovery_out     <= bus_speed_options[1:0];
            bus_speed_out        <= bus_speed_options[3:2];
            early_write_end_out  <= misc_options[OPT_WBUF_BIT];
            dma_bridge_en_out    <= !misc_options[OPT_BRIDGE_BIT];
            io_decode_16_out     <= misc_options[OPT_IO16_BIT];
            data_pipeline_en_out <= misc_options[OPT_PIPE_BIT];
            middle_bios_en_out   <= misc_options[OPT_MBIOS_BIT];
        end
    end

    // DMA flow-through handshake
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flow_state         <= FLOW_IDLE;
            write_pipe_off_out <= 1'b0;
            memctl_ready_n_out <= 1'b1;
        end else begin
            case (flow_state)
                FLOW_IDLE: begin
                    if (dma_grant_in && misc_options[OPT_FLOW_BIT]) begin
                        flow_state         <= FLOW_DRAIN;
                        write_pipe_off_out <= 1'b1;
                    end
                end
                FLOW_DRAIN: begin
                    if (!dma_grant_in) begin
                        flow_state         <= FLOW_IDLE;
                        write_pipe_off_out <= 1'b0;
                    end else if (write_buffer_empty_in) begin
                        // Ready only once nothing is left posted
                        flow_state         <= FLOW_READY;
                        memctl_ready_n_out <= 1'b0;
                    end
                end
                FLOW_READY: begin
                    if (!dma_grant_in) begin
                        flow_state         <= FLOW_IDLE;
                        write_pipe_off_out <= 1'b0;
                        memctl_ready_n_out <= 1'b1;
                    end
                end
                default: flow_state <= FLOW_IDLE;
            endcase
        end
    end

    // RAS active timeout, pulse when the limit is reached
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ras_count       <= 16'h0000;
            ras_timeout_out <= 1'b0;
        end else if (ras_active_in && bus_speed_options[SPD_TIMEOUT_BIT]) begin
            ras_count       <= ras_count + 16'h0001;
            ras_timeout_out <= ras_count == 16'(TIMEOUT_CYC - 1);
        end else begin
            ras_count       <= 16'h0000;
            ras_timeout_out <= 1'b0;
        end
    end

    // Cycle attribute decode on address bits 27:14
    logic        below_1m;
    logic        upper_page;
    logic [4:0]  desc_idx;
    logic [5:0]  desc;
    logic [13:0] remap_virt;
    logic        shadow_ok;

    assign below_1m   = host_address_bus_in[13:6] == 8'h00;
    assign upper_page = below_1m && host_address_bus_in[5:0] >= PAGE_640K;
    // Page 0 above 640K lands on descriptor address 8
    assign desc_idx   = 5'(host_address_bus_in[5:0] - DESC_ADDR_SHIFT);
    assign desc       = page_descriptor[desc_idx];
    assign remap_virt = host_address_bus_in - installed_ceiling_value;
    assign shadow_ok  = desc[DESC_SHADOW] && (cycle_write_in ?
                        desc[DESC_WRITE] : desc[DESC_READ]);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dram_select_out     <= 1'b0;
            non_cacheable_out   <= 1'b0;
            translate_hit_out   <= 1'b0;
            translated_page_out <= 14'h0000;
            remap_phys_page_out <= 5'h00;
        end else if (cycle_valid_in) begin
            if (upper_page) begin
                dram_select_out <= desc[DESC_XLATE] || shadow_ok;
            end else begin
                // Remap ceiling covers installed plus remapped pages
                dram_select_out <=
                    host_address_bus_in < remap_ceiling_value;
            end
            non_cacheable_out <=
                host_address_bus_in >= upper_cache_limit ||
                (below_1m &&
                 host_address_bus_in[5:0] >= low_noncache_window_start &&
                 host_address_bus_in[5:0] < low_noncache_window_end) ||
                (upper_page && !desc[DESC_CACHE]);
            translate_hit_out   <= upper_page && desc[DESC_XLATE];
            translated_page_out <= page_translation_entry[desc_idx];
            remap_phys_page_out <= remap_table_entry[remap_virt[4:0]];
        end else begin
            dram_select_out   <= 1'b0;
            non_cacheable_out <= 1'b0;
            translate_hit_out <= 1'b0;
        end
    end

endmodule // memctl_config_tables
`default_nettype wire

// >>> pkg/memctl_cfg_pkg.sv
// Shared constants and carrier types for the memory controller config bank
package memctl_cfg_pkg;
    // Host I/O ports
    localparam logic [7:0]  IO_INDEX_PORT     = 8'h28;
    localparam logic [7:0]  IO_DATA_PORT      = 8'h24;
    // Register indices
    localparam logic [7:0]  IDX_CAS_TIMING    = 8'h26;
    localparam logic [7:0]  IDX_RAS_TIMING    = 8'h27;
    localparam logic [7:0]  IDX_XFER_CTRL     = 8'h28;
    localparam logic [7:0]  IDX_RAM_ADDR      = 8'h29;
    localparam logic [7:0]  IDX_XFER_DATA     = 8'h2a;
    localparam logic [7:0]  IDX_MISC_OPT      = 8'h2b;
    localparam logic [7:0]  IDX_BUS_SPEED     = 8'h2d;
    // Reset values
    localparam logic [7:0]  RST_CAS_TIMING    = 8'hff;
    localparam logic [7:0]  RST_RAS_TIMING    = 8'hff;
    localparam logic [7:0]  RST_BYTE_ZERO     = 8'h00;
    localparam logic [7:0]  RST_BUS_SPEED     = 8'h03;
    localparam logic [13:0] RST_CEILING       = 14'h0040;
    localparam logic [5:0]  RST_WINDOW_START  = 6'h00;
    localparam logic [5:0]  RST_WINDOW_END    = 6'h28;
    localparam logic [13:0] RST_TRANSLATION   = 14'h0040;
    localparam logic [4:0]  RST_REMAP_ENTRY   = 5'h00;
    localparam logic [5:0]  RST_DESCRIPTOR    = 6'h00;
    // Transfer target codes
    localparam logic [3:0]  TGT_TRANS_MSB     = 4'h0;
    localparam logic [3:0]  TGT_TRANS_LSB     = 4'h1;
    localparam logic [3:0]  TGT_REMAP_RAM     = 4'h2;
    localparam logic [3:0]  TGT_DESC_RAM      = 4'h3;
    localparam logic [3:0]  TGT_CACHE_MSB     = 4'h8;
    localparam logic [3:0]  TGT_CACHE_LSB     = 4'h9;
    localparam logic [3:0]  TGT_WIN_START     = 4'ha;
    localparam logic [3:0]  TGT_WIN_END       = 4'hb;
    localparam logic [3:0]  TGT_REMAP_MSB     = 4'hc;
    localparam logic [3:0]  TGT_REMAP_LSB     = 4'hd;
    localparam logic [3:0]  TGT_INST_MSB      = 4'he;
    localparam logic [3:0]  TGT_INST_LSB      = 4'hf;
    // Field positions
    localparam int XFER_DIR_BIT   = 6;
    localparam int XFER_GO_BIT    = 7;
    localparam int OPT_WBUF_BIT   = 0;
    localparam int OPT_BRIDGE_BIT = 1;
    localparam int OPT_IO16_BIT   = 3;
    localparam int OPT_FLOW_BIT   = 4;
    localparam int OPT_PIPE_BIT   = 5;
    localparam int OPT_MBIOS_BIT  = 6;
    localparam int SPD_TIMEOUT_BIT = 4;
    localparam int DESC_SHADOW    = 0;
    localparam int DESC_READ      = 1;
    localparam int DESC_WRITE     = 2;
    localparam int DESC_CACHE     = 3;
    localparam int DESC_XLATE     = 5;
    // Upper-memory page layout, in 16KB page units
    localparam logic [5:0]  PAGE_640K         = 6'h28;
    localparam logic [5:0]  DESC_ADDR_SHIFT   = 6'h20;
    // Timing
    localparam int CLK_PERIOD_NS    = 20;
    localparam int RAS_TIMEOUT_NS   = 10000;
    localparam int RAS_TIMEOUT_CYC  = RAS_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } io_req_t;

    typedef struct packed {
        logic [2:0] row_strobe_precharge;
        logic [3:0] ras_active_read;
        logic [2:0] ras_active_write;
        logic       ras_delay;
        logic [1:0] col_strobe_precharge;
        logic [1:0] col_strobe_read_delay;
        logic [1:0] col_strobe_write_delay;
        logic [1:0] cas_active_read;
        logic [1:0] cas_active_write;
        logic [1:0] cas_burst_delay;
        logic [1:0] cas_hold;
    } dram_timing_t;

    typedef enum logic [1:0] {
        FLOW_IDLE,
        FLOW_DRAIN,
        FLOW_READY
    } flow_state_t;
endpackage

// >>> tb/memctl_cfg_sva.sv
// Port checker for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module memctl_cfg_sva
    import memctl_cfg_pkg::*;
#(
    parameter int TIMEOUT_CYC = RAS_TIMEOUT_CYC
) (
    input wire logic         clk_in,
    input wire logic         sys_rst_in,
    input wire io_req_t      host_req_in,
    input wire logic         cycle_valid_in,
    input wire logic         dma_grant_in,
    input wire logic         write_buffer_empty_in,
    input wire logic         ras_active_in,
    input wire dram_timing_t timing_out,
    input wire logic [1:0]   bus_speed_out,
    input wire logic         early_write_end_out,
    input wire logic         dma_bridge_en_out,
    input wire logic         write_pipe_off_out,
    input wire logic         memctl_ready_n_out,
    input wire logic         ras_timeout_out,
    input wire logic         dram_select_out,
    input wire logic         non_cacheable_out
);
    logic [7:0] idx;
    logic [7:0] wd;
    logic [9:0] cnt;
    logic       dw;
    assign dw = host_req_in.wr && host_req_in.addr == IO_DATA_PORT;
    // Own copy of index and data, so field checks need no decode
    always_ff @(posedge clk_in) begin
        if (sys_rst_in)
            idx <= 8'h00;
        else if (host_req_in.wr && host_req_in.addr == IO_INDEX_PORT)
            idx <= host_req_in.data;
    end
    always_ff @(posedge clk_in) begin
        if (dw)
            wd <= host_req_in.data;
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !ras_active_in)
            cnt <= '0;
        else if (cnt != 10'h3ff)
            cnt <= cnt + 10'h001;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_ras_fields: assert property (dw && idx == IDX_RAS_TIMING |->
        ##[1:2] timing_out.ras_active_read == 4'(wd[4:2]) + 4'h2 &&
        timing_out.row_strobe_precharge == 3'(wd[1:0]) + 3'h1)
        else $error("ras timing fields wrong");
    a_speed_fields: assert property (dw && idx == IDX_BUS_SPEED |->
        ##[1:2] bus_speed_out == wd[3:2]) else $error("bus speed wrong");
    a_option_bits: assert property (dw && idx == IDX_MISC_OPT |->
        ##[1:2] early_write_end_out == wd[0] && dma_bridge_en_out == !wd[1])
        else $error("option outputs wrong");
    a_ready_release: assert property (!dma_grant_in [*2] |=>
        memctl_ready_n_out && !write_pipe_off_out) else $error("ready held");
    a_ready_cause: assert property ($fell(memctl_ready_n_out) |->
        write_pipe_off_out && $past(write_buffer_empty_in))
        else $error("ready before drain");
    a_timeout_pulse: assert property (ras_timeout_out |=>
        !ras_timeout_out) else $error("timeout pulse too long");
    a_timeout_cause: assert property (ras_timeout_out |->
        cnt >= 10'(TIMEOUT_CYC - 1)) else $error("timeout too early");
    a_idle_flags: assert property (!cycle_valid_in |=>
        !dram_select_out && !non_cacheable_out) else $error("stray flag");
    c_ready: cover property (!memctl_ready_n_out);
    c_timeout: cover property (ras_timeout_out);
    c_dram: cover property (dram_select_out && non_cacheable_out);
endmodule // memctl_cfg_sva
`default_nettype wire

// >>> tb/host_model.sv
// Host processor model issuing indexed I/O accesses
`timescale 1ns/10ps
`default_nettype none
module host_model
    import memctl_cfg_pkg::*;
(
    input  wire logic [7:0] rdata_in,
    input  wire logic       clk_in,
    output var  io_req_t    req_out
);
    initial req_out = '0;
    // Idle bus shows inverted values, never the last ones
    task automatic io(input logic w, input logic [7:0] a, d);
        @(negedge clk_in);
        req_out = {w, !w, a, d};
        @(negedge clk_in);
        req_out = {2'b00, ~a, ~d};
    endtask
    task automatic put(input logic [7:0] i, v);
        io(1'b1, IO_INDEX_PORT, i);
        io(1'b1, IO_DATA_PORT, v);
    endtask
    task automatic get(input logic [7:0] i, output logic [7:0] v);
        io(1'b1, IO_INDEX_PORT, i);
        io(1'b0, IO_DATA_PORT, 8'h00);
        @(negedge clk_in);
        v = rdata_in;
    endtask
    task automatic xfer(input logic [3:0] t, input logic [7:0] v,
        output logic [7:0] r);
        put(IDX_RAM_ADDR, 8'h08);
        put(IDX_XFER_DATA, v);
        put(IDX_XFER_CTRL, {4'hc, t});
        put(IDX_XFER_DATA, ~v);
        put(IDX_XFER_CTRL, {4'h8, t});
        get(IDX_XFER_DATA, r);
    endtask
endmodule // host_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    import memctl_cfg_pkg::*;
    typedef struct packed {logic [7:0] idx, wv, rst, exp;} row_t;
    row_t rows [8] = '{'{8'h26,8'h81,8'hff,8'h81}, '{8'h27,8'h5a,8'hff,8'h5a},
        '{8'h28,8'h4b,8'h00,8'h4b}, '{8'h29,8'h15,8'h00,8'h15},
        '{8'h2a,8'ha5,8'h00,8'ha5}, '{8'h2b,8'h7b,8'h00,8'h7b},
        '{8'h2d,8'h1e,8'h03,8'h1e}, '{8'h30,8'h55,8'h00,8'h00}};
    logic clk_in = 0, sys_rst_in = 1, cycle_valid_in = 0, cycle_write_in = 1;
    logic dma_grant_in = 0, write_buffer_empty_in = 0, ras_active_in = 0;
    logic [13:0] host_address_bus_in = '0, translated_page_out;
    logic [7:0] host_data_bus_out, v, m;
    logic dram_select_out, non_cacheable_out, memctl_ready_n_out;
    logic write_pipe_off_out, ras_timeout_out, translate_hit_out;
    logic [4:0] remap_phys_page_out;
    io_req_t host_req_in;
    int err_count = 0, num_checks = 0, n = 0;
    always #10 clk_in = ~clk_in;
    host_model h (.rdata_in(host_data_bus_out), .clk_in, .req_out(host_req_in));
    memctl_config_tables #(.TIMEOUT_CYC(8)) i_dut (.clk_in, .sys_rst_in,
        .host_req_in, .host_address_bus_in, .cycle_valid_in, .cycle_write_in,
        .dma_grant_in, .write_buffer_empty_in, .ras_active_in,
        .host_data_bus_out, .timing_out(), .bus_recovery_out(),
        .bus_speed_out(), .early_write_end_out(), .dma_bridge_en_out(),
        .io_decode_16_out(), .data_pipeline_en_out(), .middle_bios_en_out(),
        .write_pipe_off_out, .memctl_ready_n_out, .ras_timeout_out,
        .dram_select_out, .non_cacheable_out, .translate_hit_out,
        .translated_page_out, .remap_phys_page_out);
    task automatic chk(input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic dec(input logic [13:0] p, input logic ds, nc);
        @(negedge clk_in);
        host_address_bus_in = p;
        cycle_valid_in = 1'b1;
        @(negedge clk_in);
        cycle_valid_in = 1'b0;
        chk(dram_select_out, ds);
        chk(non_cacheable_out, nc);
    endtask
    initial begin
        #400us;
        err_count++;
        summarize;
    end
    initial begin
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        foreach (rows[i]) begin
            h.get(rows[i].idx, v);
            chk(v, rows[i].rst);
            h.put(rows[i].idx, rows[i].wv);
            h.get(rows[i].idx, v);
            chk(v, rows[i].exp);
        end
        $display("register table done");
        for (int t = 0; t < 16; t++) begin
            m = (t == 2) ? 8'h1f : (t % 2 && t != 3 && t != 11) ? 8'hff : 8'h3f;
            h.xfer(4'(t), 8'h20 + 8'(t), v);
            chk(v, (t > 3 && t < 8) ? 8'h00 : (8'h20 + 8'(t)) & m);
        end
        $display("transfers done");
        // Page 28h: translated, cache bit clear, descriptor at address 8
        dec(14'h0028, 1'b1, 1'b1);
        chk({translate_hit_out, translated_page_out}, 15'h6021);
        dec(14'h0001, 1'b1, 1'b0);
        // Eight pages above the installed ceiling pick remap entry 8
        dec(14'h2e37, 1'b0, 1'b1);
        chk(remap_phys_page_out, 5'h02);
        $display("decode done");
        h.put(IDX_MISC_OPT, 8'h10);
        dma_grant_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk({write_pipe_off_out, memctl_ready_n_out}, 2'b11);
        write_buffer_empty_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk(memctl_ready_n_out, 1'b0);
        dma_grant_in = 1'b0;
        h.put(IDX_BUS_SPEED, 8'h10);
        ras_active_in = 1'b1;
        repeat (12) @(negedge clk_in) n += int'(ras_timeout_out);
        chk(16'(n), 16'h0001);
        $display("flow and timeout done");
        ras_active_in = 1'b0;
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        @(negedge clk_in);
        chk({memctl_ready_n_out, ras_timeout_out}, 2'b10);
        h.get(IDX_BUS_SPEED, v);
        chk(v, RST_BUS_SPEED);
        $display("reset done");
        summarize;
    end
endmodule // tb
bind memctl_config_tables memctl_cfg_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (
    .clk_in, .sys_rst_in, .host_req_in, .cycle_valid_in, .dma_grant_in,
    .write_buffer_empty_in, .ras_active_in, .timing_out, .bus_speed_out,
    .early_write_end_out, .dma_bridge_en_out, .write_pipe_off_out,
    .memctl_ready_n_out, .ras_timeout_out, .dram_select_out,
    .non_cacheable_out);
`default_nettype wire
